/* logic/iosd_pkg.sv */
package iosd_pkg;

    // register counts
    localparam int NUM_RW = 19;
    localparam int NUM_FLAG = 4;
    localparam int NUM_PIN = 3;

    // plain storage registers, I/O offsets
    localparam logic [5:0] OFS_PORT_B_DIRECTION = 6'h04;
    localparam logic [5:0] OFS_PORT_B_OUTPUT_LATCH = 6'h05;
    localparam logic [5:0] OFS_PORT_C_DIRECTION = 6'h07;
    localparam logic [5:0] OFS_PORT_C_OUTPUT_LATCH = 6'h08;
    localparam logic [5:0] OFS_PORT_D_DIRECTION = 6'h0A;
    localparam logic [5:0] OFS_PORT_D_OUTPUT_LATCH = 6'h0B;
    localparam logic [5:0] OFS_EEPROM_CONTROL = 6'h1F;
    localparam logic [5:0] OFS_EEPROM_DATA = 6'h20;
    localparam logic [5:0] OFS_EEPROM_ADDRESS_LOW = 6'h21;
    localparam logic [5:0] OFS_EEPROM_ADDRESS_HIGH = 6'h22;
    localparam logic [5:0] OFS_GENERAL_TIMER_CONTROL = 6'h23;
    localparam logic [5:0] OFS_TIMER0_CONTROL_A = 6'h24;
    localparam logic [5:0] OFS_TIMER0_CONTROL_B = 6'h25;
    localparam logic [5:0] OFS_TIMER0_COUNT = 6'h26;
    localparam logic [5:0] OFS_TIMER0_COMPARE_A = 6'h27;
    localparam logic [5:0] OFS_TIMER0_COMPARE_B = 6'h28;
    localparam logic [5:0] OFS_SCRATCH_REGISTER_1 = 6'h2A;
    localparam logic [5:0] OFS_SCRATCH_REGISTER_2 = 6'h2B;
    localparam logic [5:0] OFS_SERIAL_PERIPHERAL_CONTROL = 6'h2C;

    // write-one-to-clear flag registers
    localparam logic [5:0] OFS_TIMER0_FLAGS = 6'h15;
    localparam logic [5:0] OFS_TIMER1_FLAGS = 6'h16;
    localparam logic [5:0] OFS_TIMER2_FLAGS = 6'h17;
    localparam logic [5:0] OFS_PIN_CHANGE_FLAGS = 6'h1B;

    // pin input registers
    localparam logic [5:0] OFS_PORT_B_PIN_INPUT = 6'h03;
    localparam logic [5:0] OFS_PORT_C_PIN_INPUT = 6'h06;
    localparam logic [5:0] OFS_PORT_D_PIN_INPUT = 6'h09;

    // implemented bits per register
    localparam logic [7:0] MASK_FULL = 8'hFF;
    localparam logic [7:0] MASK_PORT_C = 8'h7F;
    localparam logic [7:0] MASK_TIMER0_FLAGS = 8'h07;
    localparam logic [7:0] MASK_TIMER1_FLAGS = 8'h27;
    localparam logic [7:0] MASK_TIMER2_FLAGS = 8'h07;
    localparam logic [7:0] MASK_PIN_CHANGE_FLAGS = 8'h07;

    // tables in instance order
    localparam logic [NUM_RW-1:0][5:0] RW_OFS = {
        OFS_SERIAL_PERIPHERAL_CONTROL, OFS_SCRATCH_REGISTER_2,
        OFS_SCRATCH_REGISTER_1, OFS_TIMER0_COMPARE_B,
        OFS_TIMER0_COMPARE_A, OFS_TIMER0_COUNT, OFS_TIMER0_CONTROL_B,
        OFS_TIMER0_CONTROL_A, OFS_GENERAL_TIMER_CONTROL,
        OFS_EEPROM_ADDRESS_HIGH, OFS_EEPROM_ADDRESS_LOW, OFS_EEPROM_DATA,
        OFS_EEPROM_CONTROL, OFS_PORT_D_OUTPUT_LATCH, OFS_PORT_D_DIRECTION,
        OFS_PORT_C_OUTPUT_LATCH, OFS_PORT_C_DIRECTION,
        OFS_PORT_B_OUTPUT_LATCH, OFS_PORT_B_DIRECTION};
    localparam logic [NUM_RW-1:0][7:0] RW_MASK = {
        MASK_FULL, MASK_FULL, MASK_FULL, MASK_FULL, MASK_FULL, MASK_FULL,
        MASK_FULL, MASK_FULL, MASK_FULL, MASK_FULL, MASK_FULL, MASK_FULL,
        MASK_FULL, MASK_FULL, MASK_FULL, MASK_PORT_C, MASK_PORT_C,
        MASK_FULL, MASK_FULL};
    localparam int IDX_PORT_B_DIRECTION = 0;
    localparam int IDX_PORT_B_OUTPUT_LATCH = 1;
    localparam int IDX_PORT_C_DIRECTION = 2;
    localparam int IDX_PORT_C_OUTPUT_LATCH = 3;
    localparam int IDX_PORT_D_DIRECTION = 4;
    localparam int IDX_PORT_D_OUTPUT_LATCH = 5;

    localparam logic [NUM_FLAG-1:0][5:0] FLAG_OFS = {
        OFS_PIN_CHANGE_FLAGS, OFS_TIMER2_FLAGS, OFS_TIMER1_FLAGS,
        OFS_TIMER0_FLAGS};
    localparam logic [NUM_FLAG-1:0][7:0] FLAG_MASK = {
        MASK_PIN_CHANGE_FLAGS, MASK_TIMER2_FLAGS, MASK_TIMER1_FLAGS,
        MASK_TIMER0_FLAGS};

    localparam logic [NUM_PIN-1:0][5:0] PIN_OFS = {
        OFS_PORT_D_PIN_INPUT, OFS_PORT_C_PIN_INPUT, OFS_PORT_B_PIN_INPUT};
    localparam logic [NUM_PIN-1:0][7:0] PIN_MASK = {
        MASK_FULL, MASK_PORT_C, MASK_FULL};

    // address windows
    localparam logic [5:0] BIT_LAST = 6'h1F;
    localparam logic [7:0] DS_IO_BASE = 8'h20;
    localparam logic [7:0] DS_EXT_BASE = 8'h60;

    // values after reset
    localparam logic [7:0] RST_VALUE = 8'h00;
    localparam logic [5:0] RST_ADDR = 6'h00;
    localparam logic [7:0] RST_EXT_ADDR = 8'h00;

    // kind of access taken in a cycle
    typedef enum logic [2:0] {
        ACC_NONE = 3'b000,
        ACC_READ = 3'b001,
        ACC_WRITE = 3'b010,
        ACC_TEST = 3'b011,
        ACC_EXT = 3'b100,
        ACC_BAD = 3'b101
    } iosd_acc_t;

endpackage : iosd_pkg

/* logic/iosd_rw_reg.sv */
`timescale 1ns/1ns
module iosd_rw_reg #(
    parameter logic [7:0] MASK = 8'hFF
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // masked write
    input wire logic wr_en,
    input wire logic [7:0] wr_mask,
    input wire logic [7:0] wr_data,
    // stored value
    output logic [7:0] value
);
    typedef struct packed {
        logic [7:0] val_r;
    } iosd_rw_state_t;

    iosd_rw_state_t s_r;
    iosd_rw_state_t s_nxt;
    logic [7:0] m;

    always_comb begin
        s_nxt = s_r;
        m = wr_mask & MASK;
        // only masked bits change, reserved bits stay zero
        if (wr_en) begin
            s_nxt.val_r = (s_r.val_r & ~m) | (wr_data & m);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r.val_r <= iosd_pkg::RST_VALUE;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    assign value = s_r.val_r;

endmodule : iosd_rw_reg

/* logic/iosd_w1c_reg.sv */
`timescale 1ns/1ns
module iosd_w1c_reg #(
    parameter logic [7:0] MASK = 8'hFF
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // hardware events
    input wire logic [7:0] set,
    // masked write, a one clears
    input wire logic wr_en,
    input wire logic [7:0] wr_mask,
    input wire logic [7:0] wr_data,
    // flag value
    output logic [7:0] value
);
    typedef struct packed {
        logic [7:0] flag_r;
    } iosd_w1c_state_t;

    iosd_w1c_state_t s_r;
    iosd_w1c_state_t s_nxt;
    logic [7:0] clr;

    always_comb begin
        s_nxt = s_r;
        clr = wr_en ? (wr_mask & wr_data & MASK) : 8'h00;
        // set wins over a clear in the same cycle
        s_nxt.flag_r = ((s_r.flag_r & ~clr) | set) & MASK;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r.flag_r <= iosd_pkg::RST_VALUE;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    assign value = s_r.flag_r;

endmodule : iosd_w1c_reg

/* logic/iosd_top.sv */
`timescale 1ns/1ns
// What this block does
// - bit set and clear work on I/O addresses 0x00-0x1F only, refused above.
// - skip tests test one selected bit of a bit-accessible register.
// - some status flags clear when written with one; writing zero keeps them.
// - bit set or clear touches only the addressed bit, no other flag.
// - I/O in and out instructions address locations 0x00 through 0x3F.
// - load and store reach the same registers at I/O address plus 0x20.
// - data addresses 0x60-0xFF reached only by load and store, not I/O.
module iosd_top (
    // clock, reset, enable
    input wire logic CORE_CLK,
    input wire logic RSTN,
    input wire logic CLK_EN,
    // I/O in and out instructions
    input wire logic IO_RD,
    input wire logic IO_WR,
    input wire logic [5:0] IO_ADDR,
    input wire logic [7:0] IO_WDATA,
    // data-space load and store
    input wire logic DS_RD,
    input wire logic DS_WR,
    input wire logic [7:0] DS_ADDR,
    input wire logic [7:0] DS_WDATA,
    // single-bit instructions
    input wire logic BIT_SET,
    input wire logic BIT_CLR,
    input wire logic SKIP_IF_SET,
    input wire logic SKIP_IF_CLR,
    input wire logic [5:0] BIT_ADDR,
    input wire logic [2:0] BIT_SEL,
    // answer to the core
    output logic [7:0] RD_DATA,
    output logic RD_VALID,
    output logic SKIP,
    output logic REFUSED,
    // extended I/O space
    output logic EXT_RD,
    output logic EXT_WR,
    output logic [7:0] EXT_ADDR,
    output logic [7:0] EXT_WDATA,
    input wire logic [7:0] EXT_RDATA,
    // port pins and settings
    input wire logic [7:0] PORT_B_PINS,
    input wire logic [7:0] PORT_C_PINS,
    input wire logic [7:0] PORT_D_PINS,
    output logic [7:0] PORT_B_DIR,
    output logic [7:0] PORT_B_OUT,
    output logic [7:0] PORT_C_DIR,
    output logic [7:0] PORT_C_OUT,
    output logic [7:0] PORT_D_DIR,
    output logic [7:0] PORT_D_OUT,
    // flag events from peripherals
    input wire logic [7:0] TIMER0_EVENTS,
    input wire logic [7:0] TIMER1_EVENTS,
    input wire logic [7:0] TIMER2_EVENTS,
    input wire logic [7:0] PIN_CHANGE_EVENTS,
    // write notice to peripherals
    output logic WR_STROBE,
    output logic [5:0] WR_ADDR,
    output logic [7:0] WR_MASK,
    output logic [7:0] WR_DATA
);
    typedef struct packed {
        logic [7:0] rd_data_r;
        logic rd_valid_r;
        logic skip_r;
        logic refused_r;
        logic ext_rd_r;
        logic ext_wr_r;
        logic [7:0] ext_addr_r;
        logic [7:0] ext_wdata_r;
        logic wr_strobe_r;
        logic [5:0] wr_addr_r;
        logic [7:0] wr_mask_r;
        logic [7:0] wr_data_r;
    } iosd_top_state_t;

    iosd_top_state_t s_r;
    iosd_top_state_t s_nxt;

    iosd_pkg::iosd_acc_t acc;
    logic [5:0] acc_addr;
    logic [7:0] acc_mask;
    logic [7:0] acc_wdata;
    logic acc_skip_set;
    logic [7:0] rd_val;
    logic sel_bit;
    logic [iosd_pkg::NUM_RW-1:0] rw_we;
    logic [iosd_pkg::NUM_FLAG-1:0] flag_we;
    logic [iosd_pkg::NUM_RW-1:0][7:0] rw_val;
    logic [iosd_pkg::NUM_FLAG-1:0][7:0] flag_val;
    logic [iosd_pkg::NUM_FLAG-1:0][7:0] flag_set;
    logic [iosd_pkg::NUM_PIN-1:0][7:0] pin_val;

    assign flag_set = {PIN_CHANGE_EVENTS, TIMER2_EVENTS, TIMER1_EVENTS,
                       TIMER0_EVENTS};
    assign pin_val = {PORT_D_PINS, PORT_C_PINS, PORT_B_PINS};

    // access decode, one request per cycle in fixed priority
    always_comb begin
        acc = iosd_pkg::ACC_NONE;
        acc_addr = iosd_pkg::RST_ADDR;
        acc_mask = iosd_pkg::MASK_FULL;
        acc_wdata = iosd_pkg::RST_VALUE;
        acc_skip_set = 1'b0;
        if (IO_RD || IO_WR) begin
            // full 6-bit window, 64 locations
            acc_addr = IO_ADDR;
            acc_wdata = IO_WDATA;
            acc = IO_WR ? iosd_pkg::ACC_WRITE : iosd_pkg::ACC_READ;
        end else if (DS_RD || DS_WR) begin
            if (DS_ADDR >= iosd_pkg::DS_EXT_BASE) begin
                acc = iosd_pkg::ACC_EXT;
            end else if (DS_ADDR >= iosd_pkg::DS_IO_BASE) begin
                acc_addr = 6'(DS_ADDR - iosd_pkg::DS_IO_BASE);
                acc_wdata = DS_WDATA;
                acc = DS_WR ? iosd_pkg::ACC_WRITE : iosd_pkg::ACC_READ;
            end else begin
                acc = iosd_pkg::ACC_BAD;
            end
        end else if (BIT_SET || BIT_CLR || SKIP_IF_SET || SKIP_IF_CLR) begin
            if (BIT_ADDR > iosd_pkg::BIT_LAST) begin
                acc = iosd_pkg::ACC_BAD;
            end else begin
                acc_addr = BIT_ADDR;
                acc_mask = 8'(8'h01 << BIT_SEL);
                if (BIT_SET || BIT_CLR) begin
                    acc = iosd_pkg::ACC_WRITE;
                    acc_wdata = BIT_SET ? 8'hFF : 8'h00;
                end else begin
                    acc = iosd_pkg::ACC_TEST;
                    acc_skip_set = SKIP_IF_SET;
                end
            end
        end
    end

    // write enables per register
    always_comb begin
        rw_we = '0;
        flag_we = '0;
        for (int i = 0; i < iosd_pkg::NUM_RW; i++) begin
            rw_we[i] = (acc == iosd_pkg::ACC_WRITE) &&
                       (acc_addr == iosd_pkg::RW_OFS[i]);
        end
        for (int j = 0; j < iosd_pkg::NUM_FLAG; j++) begin
            flag_we[j] = (acc == iosd_pkg::ACC_WRITE) &&
                         (acc_addr == iosd_pkg::FLAG_OFS[j]);
        end
    end

    // read mux, unmapped locations read zero
    always_comb begin
        rd_val = iosd_pkg::RST_VALUE;
        for (int i = 0; i < iosd_pkg::NUM_RW; i++) begin
            if (acc_addr == iosd_pkg::RW_OFS[i]) begin
                rd_val = rw_val[i];
            end
        end
        for (int j = 0; j < iosd_pkg::NUM_FLAG; j++) begin
            if (acc_addr == iosd_pkg::FLAG_OFS[j]) begin
                rd_val = flag_val[j];
            end
        end
        for (int k = 0; k < iosd_pkg::NUM_PIN; k++) begin
            if (acc_addr == iosd_pkg::PIN_OFS[k]) begin
                rd_val = pin_val[k] & iosd_pkg::PIN_MASK[k];
            end
        end
        sel_bit = rd_val[BIT_SEL];
    end

    genvar g;
    generate
        for (g = 0; g < iosd_pkg::NUM_RW; g++) begin : g_rw
            iosd_rw_reg #(
                .MASK(iosd_pkg::RW_MASK[g])
            ) u_reg (
                .clk(CORE_CLK),
                .rst_n(RSTN),
                .ce(CLK_EN),
                .wr_en(rw_we[g]),
                .wr_mask(acc_mask),
                .wr_data(acc_wdata),
                .value(rw_val[g])
            );
        end
        for (g = 0; g < iosd_pkg::NUM_FLAG; g++) begin : g_flag
            iosd_w1c_reg #(
                .MASK(iosd_pkg::FLAG_MASK[g])
            ) u_flag (
                .clk(CORE_CLK),
                .rst_n(RSTN),
                .ce(CLK_EN),
                .set(flag_set[g]),
                .wr_en(flag_we[g]),
                .wr_mask(acc_mask),
                .wr_data(acc_wdata),
                .value(flag_val[g])
            );
        end
    endgenerate

    // answer and notice registers
    always_comb begin
        s_nxt = s_r;
        s_nxt.rd_valid_r = 1'b0;
        s_nxt.refused_r = 1'b0;
        s_nxt.wr_strobe_r = 1'b0;
        s_nxt.ext_rd_r = 1'b0;
        s_nxt.ext_wr_r = 1'b0;
        // ext data only stands while the read strobe is high
        if (s_r.ext_rd_r) begin
            s_nxt.rd_data_r = EXT_RDATA;
            s_nxt.rd_valid_r = 1'b1;
            s_nxt.skip_r = 1'b0;
        end
        case (acc)
            iosd_pkg::ACC_READ: begin
                s_nxt.rd_data_r = rd_val;
                s_nxt.rd_valid_r = 1'b1;
                s_nxt.skip_r = 1'b0;
            end
            iosd_pkg::ACC_TEST: begin
                s_nxt.rd_data_r = rd_val;
                s_nxt.rd_valid_r = 1'b1;
                s_nxt.skip_r = acc_skip_set ? sel_bit : !sel_bit;
            end
            iosd_pkg::ACC_WRITE: begin
                s_nxt.wr_strobe_r = 1'b1;
                s_nxt.wr_addr_r = acc_addr;
                s_nxt.wr_mask_r = acc_mask;
                s_nxt.wr_data_r = acc_wdata;
            end
            iosd_pkg::ACC_EXT: begin
                s_nxt.ext_rd_r = DS_RD;
                s_nxt.ext_wr_r = !DS_RD;
                s_nxt.ext_addr_r = DS_ADDR;
                s_nxt.ext_wdata_r = DS_WDATA;
            end
            iosd_pkg::ACC_BAD: begin
                s_nxt.refused_r = 1'b1;
            end
            default: begin
                s_nxt.refused_r = 1'b0;
            end
        endcase
    end

    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            s_r.rd_data_r <= iosd_pkg::RST_VALUE;
            s_r.rd_valid_r <= 1'b0;
            s_r.skip_r <= 1'b0;
            s_r.refused_r <= 1'b0;
            s_r.ext_rd_r <= 1'b0;
            s_r.ext_wr_r <= 1'b0;
            s_r.ext_addr_r <= iosd_pkg::RST_EXT_ADDR;
            s_r.ext_wdata_r <= iosd_pkg::RST_VALUE;
            s_r.wr_strobe_r <= 1'b0;
            s_r.wr_addr_r <= iosd_pkg::RST_ADDR;
            s_r.wr_mask_r <= iosd_pkg::RST_VALUE;
            s_r.wr_data_r <= iosd_pkg::RST_VALUE;
        end else if (CLK_EN) begin
            s_r <= s_nxt;
        end
    end

    assign RD_DATA = s_r.rd_data_r;
    assign RD_VALID = s_r.rd_valid_r;
    assign SKIP = s_r.skip_r;
    assign REFUSED = s_r.refused_r;
    assign EXT_RD = s_r.ext_rd_r;
    assign EXT_WR = s_r.ext_wr_r;
    assign EXT_ADDR = s_r.ext_addr_r;
    assign EXT_WDATA = s_r.ext_wdata_r;
    assign WR_STROBE = s_r.wr_strobe_r;
    assign WR_ADDR = s_r.wr_addr_r;
    assign WR_MASK = s_r.wr_mask_r;
    assign WR_DATA = s_r.wr_data_r;
    assign PORT_B_DIR = rw_val[iosd_pkg::IDX_PORT_B_DIRECTION];
    assign PORT_B_OUT = rw_val[iosd_pkg::IDX_PORT_B_OUTPUT_LATCH];
    assign PORT_C_DIR = rw_val[iosd_pkg::IDX_PORT_C_DIRECTION];
    assign PORT_C_OUT = rw_val[iosd_pkg::IDX_PORT_C_OUTPUT_LATCH];
    assign PORT_D_DIR = rw_val[iosd_pkg::IDX_PORT_D_DIRECTION];
    assign PORT_D_OUT = rw_val[iosd_pkg::IDX_PORT_D_OUTPUT_LATCH];

endmodule : iosd_top

/* bench/iosd_chk_sva.sv */
`timescale 1ns/1ns
module iosd_chk (
    // clock and reset
    input wire logic CORE_CLK,
    input wire logic RSTN,
    input wire logic CLK_EN,
    // requests
    input wire logic IO_RD,
    input wire logic IO_WR,
    input wire logic DS_RD,
    input wire logic DS_WR,
    input wire logic [7:0] DS_ADDR,
    input wire logic [7:0] DS_WDATA,
    input wire logic BIT_SET,
    input wire logic BIT_CLR,
    input wire logic SKIP_IF_SET,
    input wire logic SKIP_IF_CLR,
    input wire logic [5:0] BIT_ADDR,
    input wire logic [2:0] BIT_SEL,
    // answers
    input wire logic [7:0] RD_DATA,
    input wire logic RD_VALID,
    input wire logic SKIP,
    input wire logic REFUSED,
    input wire logic EXT_RD,
    input wire logic [7:0] EXT_ADDR,
    input wire logic [7:0] PORT_B_OUT,
    input wire logic WR_STROBE
);
    logic io;
    logic ds;
    logic bt;
    assign io = CLK_EN & (IO_RD | IO_WR);
    assign ds = CLK_EN & ~(IO_RD | IO_WR) & (DS_RD | DS_WR);
    assign bt = CLK_EN & ~(IO_RD | IO_WR | DS_RD | DS_WR);
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!RSTN);
    a_bit_refuse: assert property (
        bt && (BIT_SET || BIT_CLR) && BIT_ADDR > 6'h1F
        |=> REFUSED && !WR_STROBE) else $error("bit op above 1F taken");
    a_bit_set_one: assert property (
        bt && BIT_SET && BIT_ADDR == 6'h05 |=> PORT_B_OUT ==
        ($past(PORT_B_OUT) | (8'h01 << $past(BIT_SEL))))
        else $error("bit set changed other bits");
    a_bit_clr_one: assert property (
        bt && !BIT_SET && BIT_CLR && BIT_ADDR == 6'h05 |=> PORT_B_OUT ==
        ($past(PORT_B_OUT) & ~(8'h01 << $past(BIT_SEL))))
        else $error("bit clear changed other bits");
    a_skip_on_set: assert property (
        bt && !BIT_SET && !BIT_CLR && SKIP_IF_SET && BIT_ADDR <= 6'h1F
        |=> RD_VALID && SKIP == RD_DATA[$past(BIT_SEL)])
        else $error("skip if set wrong");
    a_skip_on_clr: assert property (
        bt && !BIT_SET && !BIT_CLR && !SKIP_IF_SET && SKIP_IF_CLR &&
        BIT_ADDR <= 6'h1F |=> RD_VALID && SKIP != RD_DATA[$past(BIT_SEL)])
        else $error("skip if clear wrong");
    a_io_read: assert property (
        io && !IO_WR |=> RD_VALID && !SKIP && !EXT_RD)
        else $error("io read answer wrong");
    a_ds_refuse: assert property (
        ds && DS_ADDR < 8'h20 |=> REFUSED) else $error("low ds not refused");
    a_ds_latch: assert property (
        ds && !DS_RD && DS_ADDR == 8'h25 |=> PORT_B_OUT == $past(DS_WDATA))
        else $error("ds store missed latch");
    a_ext_read: assert property (
        ds && DS_RD && DS_ADDR >= 8'h60 |=> EXT_RD &&
        EXT_ADDR == $past(DS_ADDR) ##1 RD_VALID)
        else $error("ext load not forwarded");
    a_bit_notice: assert property (
        bt && (BIT_SET || BIT_CLR) && BIT_ADDR <= 6'h1F |=> WR_STROBE)
        else $error("bit op gave no write notice");
    c_refused: cover property (REFUSED);
    c_skip: cover property (RD_VALID && SKIP);
    c_ext: cover property (EXT_RD ##1 RD_VALID);
endmodule : iosd_chk

/* bench/iosd_ext_model.sv */
`timescale 1ns/1ns
module iosd_ext_model (
    // clock
    input wire logic clk,
    // extended space strobes
    input wire logic ext_rd,
    input wire logic ext_wr,
    input wire logic [7:0] ext_addr,
    input wire logic [7:0] ext_wdata,
    // read answer
    output logic [7:0] ext_rdata
);
    logic [7:0] mem_r [256];
    logic [7:0] last_r = 8'h00;
    always @(posedge clk) begin
        if (ext_wr) begin
            mem_r[ext_addr] <= ext_wdata;
        end
        if (ext_rd) begin
            last_r <= mem_r[ext_addr];
        end
    end
    // idle bus shows the inverse of the last answer
    assign ext_rdata = ext_rd ? mem_r[ext_addr] : ~last_r;
endmodule : iosd_ext_model

/* bench/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
    logic CORE_CLK = 1'b0;
    logic RSTN = 1'b0;
    logic CLK_EN = 1'b0;
    logic [7:0] req = 8'h00;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic [2:0] sel = 3'h0;
    logic [7:0] ev = 8'h00;
    logic [7:0] pb = 8'h00;
    logic [7:0] pc = 8'h00;
    logic [7:0] pd = 8'h00;
    logic [7:0] RD_DATA, EXT_ADDR, EXT_WDATA, EXT_RDATA, PORT_B_OUT;
    logic [7:0] PORT_C_OUT;
    logic RD_VALID, SKIP, REFUSED, EXT_RD, EXT_WR;
    logic [8:0] q [$];
    logic [8:0] e_mon;
    logic [7:0] v;
    logic [7:0] ofs;
    logic [31:0] seed = 32'h00000030;
    int errors = 0;
    int num_checks = 0;
    localparam int IR = 0, IW = 1, DR = 2, DW = 3, BS = 4, BC = 5;
    localparam int SS = 6, SC = 7;
    localparam logic [4:0][7:0] RESV = {8'h00, 8'h01, 8'h0C, 8'h18, 8'h29};

    iosd_top dut (.CORE_CLK(CORE_CLK), .RSTN(RSTN), .CLK_EN(CLK_EN),
        .IO_RD(req[7]), .IO_WR(req[6]), .IO_ADDR(addr[5:0]),
        .IO_WDATA(wdata), .DS_RD(req[5]), .DS_WR(req[4]), .DS_ADDR(addr),
        .DS_WDATA(wdata), .BIT_SET(req[3]), .BIT_CLR(req[2]),
        .SKIP_IF_SET(req[1]), .SKIP_IF_CLR(req[0]), .BIT_ADDR(addr[5:0]),
        .BIT_SEL(sel), .RD_DATA(RD_DATA), .RD_VALID(RD_VALID), .SKIP(SKIP),
        .REFUSED(REFUSED), .EXT_RD(EXT_RD), .EXT_WR(EXT_WR),
        .EXT_ADDR(EXT_ADDR), .EXT_WDATA(EXT_WDATA), .EXT_RDATA(EXT_RDATA),
        .PORT_B_PINS(pb), .PORT_C_PINS(pc), .PORT_D_PINS(pd),
        .PORT_B_DIR(), .PORT_B_OUT(PORT_B_OUT), .PORT_C_DIR(),
        .PORT_C_OUT(PORT_C_OUT), .PORT_D_DIR(), .PORT_D_OUT(),
        .TIMER0_EVENTS(ev), .TIMER1_EVENTS(ev), .TIMER2_EVENTS(ev),
        .PIN_CHANGE_EVENTS(ev), .WR_STROBE(), .WR_ADDR(), .WR_MASK(),
        .WR_DATA());
    iosd_ext_model ext_model (.clk(CORE_CLK), .ext_rd(EXT_RD),
        .ext_wr(EXT_WR), .ext_addr(EXT_ADDR), .ext_wdata(EXT_WDATA),
        .ext_rdata(EXT_RDATA));

    initial begin
        forever #4 CORE_CLK = ~CORE_CLK;
    end

    function automatic logic [7:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction : xs

    task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic final_report();
        $display("checks=%0d errors=%0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : final_report

    // one request per call, back to back; a gap after ext loads
    task automatic acc(input int k, input logic [7:0] a, input logic [7:0] d,
        input logic [2:0] b, input logic note, input logic [8:0] e);
        @(negedge CORE_CLK);
        req = 8'h80 >> k;
        addr = a;
        wdata = d;
        sel = b;
        if (note) begin
            q.push_back(e);
        end
        if (k == DR && a >= 8'h60) begin
            @(negedge CORE_CLK);
            req = 8'h00;
        end
    endtask : acc

    task automatic wr(input int k, input logic [7:0] a, input logic [7:0] d);
        acc(k, a, d, 3'h0, 1'b0, 9'h000);
    endtask : wr

    task automatic rd(input int k, input logic [7:0] a, input logic [2:0] b,
        input logic [7:0] e, input logic s);
        acc(k, a, 8'h00, b, 1'b1, {s, e});
    endtask : rd

    task automatic idle();
        @(negedge CORE_CLK);
        req = 8'h00;
    endtask : idle

    always @(negedge CORE_CLK) begin
        if (RD_VALID === 1'b1) begin
            if (q.size() > 0) begin
                e_mon = q.pop_front();
                chk({SKIP, RD_DATA}, e_mon);
            end else begin
                chk({SKIP, RD_DATA}, ~{SKIP, RD_DATA});
            end
        end
    end

    initial begin
        repeat (5000) @(posedge CORE_CLK);
        errors++;
        final_report();
    end

    initial begin
        repeat (8) @(posedge CORE_CLK);
        @(negedge CORE_CLK);
        RSTN = 1'b1;
        CLK_EN = 1'b1;
        pb = xs();
        pc = xs();
        pd = xs();
        // storage through I/O, read back through data space
        for (int i = 0; i < iosd_pkg::NUM_RW; i++) begin
            v = xs() & iosd_pkg::RW_MASK[i];
            ofs = {2'b00, iosd_pkg::RW_OFS[i]};
            wr(IW, ofs, v);
            rd(DR, ofs + iosd_pkg::DS_IO_BASE, 3'h0, v, 1'b0);
        end
        rd(IR, 8'h03, 3'h0, pb, 1'b0);
        rd(IR, 8'h06, 3'h0, pc & 8'h7F, 1'b0);
        rd(IR, 8'h09, 3'h0, pd, 1'b0);
        for (int b = 0; b < 8; b++) begin
            rd(SS, 8'h03, 3'(b), pb, pb[b]);
            rd(SC, 8'h03, 3'(b), pb, ~pb[b]);
        end
        // reserved bits and reserved places
        wr(IW, 8'h08, 8'hFF);
        rd(IR, 8'h08, 3'h0, 8'h7F, 1'b0);
        for (int i = 0; i < 5; i++) begin
            rd(IR, RESV[i], 3'h0, 8'h00, 1'b0);
        end
        // single-bit ops on a port latch, refused above 1F
        wr(DW, 8'h25, 8'h00);
        acc(BS, 8'h05, 8'h00, 3'h3, 1'b0, 9'h000);
        acc(BS, 8'h05, 8'h00, 3'h6, 1'b0, 9'h000);
        acc(BC, 8'h05, 8'h00, 3'h3, 1'b0, 9'h000);
        idle();
        chk({1'b0, PORT_B_OUT}, 9'h040);
        chk({1'b0, PORT_C_OUT}, 9'h07F);
        wr(IW, 8'h24, 8'h5A);
        acc(BS, 8'h24, 8'h00, 3'h0, 1'b0, 9'h000);
        idle();
        chk({8'h00, REFUSED}, 9'h001);
        rd(IR, 8'h24, 3'h0, 8'h5A, 1'b0);
        wr(DW, 8'h10, 8'h55);
        idle();
        chk({8'h00, REFUSED}, 9'h001);
        // write-one-to-clear flags
        @(negedge CORE_CLK);
        ev = 8'hFF;
        @(negedge CORE_CLK);
        ev = 8'h00;
        for (int i = 0; i < iosd_pkg::NUM_FLAG; i++) begin
            ofs = {2'b00, iosd_pkg::FLAG_OFS[i]};
            rd(IR, ofs, 3'h0, iosd_pkg::FLAG_MASK[i], 1'b0);
        end
        wr(IW, 8'h16, 8'h00);
        rd(IR, 8'h16, 3'h0, 8'h27, 1'b0);
        acc(BS, 8'h16, 8'h00, 3'h0, 1'b0, 9'h000);
        acc(BC, 8'h16, 8'h00, 3'h1, 1'b0, 9'h000);
        rd(IR, 8'h16, 3'h0, 8'h26, 1'b0);
        wr(IW, 8'h16, 8'h20);
        rd(IR, 8'h16, 3'h0, 8'h06, 1'b0);
        for (int i = 0; i < iosd_pkg::NUM_FLAG; i++) begin
            ofs = {2'b00, iosd_pkg::FLAG_OFS[i]};
            wr(DW, ofs + iosd_pkg::DS_IO_BASE, 8'hFF);
            rd(IR, ofs, 3'h0, 8'h00, 1'b0);
        end
        // extended space through the far-side model
        v = xs();
        wr(DW, 8'h80, v);
        rd(DR, 8'h80, 3'h0, v, 1'b0);
        wr(DW, 8'hFF, ~v);
        rd(DR, 8'hFF, 3'h0, ~v, 1'b0);
        // a low enable freezes the registers
        wr(IW, 8'h2A, 8'h3C);
        idle();
        CLK_EN = 1'b0;
        wr(IW, 8'h2A, 8'hC3);
        idle();
        CLK_EN = 1'b1;
        rd(IR, 8'h2A, 3'h0, 8'h3C, 1'b0);
        idle();
        repeat (4) @(negedge CORE_CLK);
        chk(9'(q.size()), 9'h000);
        final_report();
    end
endmodule : tb_top

bind iosd_top iosd_chk u_chk (.CORE_CLK(CORE_CLK), .RSTN(RSTN),
    .CLK_EN(CLK_EN), .IO_RD(IO_RD), .IO_WR(IO_WR), .DS_RD(DS_RD),
    .DS_WR(DS_WR), .DS_ADDR(DS_ADDR), .DS_WDATA(DS_WDATA),
    .BIT_SET(BIT_SET), .BIT_CLR(BIT_CLR), .SKIP_IF_SET(SKIP_IF_SET),
    .SKIP_IF_CLR(SKIP_IF_CLR), .BIT_ADDR(BIT_ADDR), .BIT_SEL(BIT_SEL),
    .RD_DATA(RD_DATA), .RD_VALID(RD_VALID), .SKIP(SKIP),
    .REFUSED(REFUSED), .EXT_RD(EXT_RD), .EXT_ADDR(EXT_ADDR),
    .PORT_B_OUT(PORT_B_OUT), .WR_STROBE(WR_STROBE));
